/* File: verilog/pin_mux_pkg.sv */
package pin_mux_pkg;

  localparam int unsigned ADDR_W      = 12;
  localparam int unsigned DATA_W      = 32;
  localparam int unsigned PIN_W       = 6;
  localparam int unsigned COEX_W      = 3;

  // Pin numbering follows the package balls; index 2 is not bonded out
  localparam logic [PIN_W-1:0] PIN_IMPL_MASK = 6'h3B;
  localparam int unsigned PIN_STRAP   = 0;
  localparam int unsigned PIN_FREQ    = 1;
  localparam int unsigned PIN_COEX_LO = 3;

  // Register byte addresses
  localparam logic [ADDR_W-1:0] ADDR_OUT      = 12'h000;
  localparam logic [ADDR_W-1:0] ADDR_DIR      = 12'h004;
  localparam logic [ADDR_W-1:0] ADDR_PULL_EN  = 12'h008;
  localparam logic [ADDR_W-1:0] ADDR_PULL_UP  = 12'h00C;
  localparam logic [ADDR_W-1:0] ADDR_IN       = 12'h010;
  localparam logic [ADDR_W-1:0] ADDR_FUNC     = 12'h014;
  localparam logic [ADDR_W-1:0] ADDR_STATUS   = 12'h018;

  // Function select fields
  localparam int unsigned FUNC_COEX_GPIO = 0;
  localparam int unsigned FUNC_FREQ_OUT  = 1;
  localparam int unsigned FUNC_UART_EN   = 2;
  localparam int unsigned FUNC_W         = 3;

  // Status fields
  localparam int unsigned STAT_SPI_MODE  = 0;
  localparam int unsigned STAT_STRAP_OK  = 1;

  // Reset values
  localparam logic [PIN_W-1:0]  RST_PINS = 6'h00;
  localparam logic [FUNC_W-1:0] RST_FUNC = 3'h0;
  localparam logic [DATA_W-1:0] RST_DATA = 32'h0000_0000;

  typedef enum logic [2:0] {
    REG_OUT     = 3'h0,
    REG_DIR     = 3'h1,
    REG_PULL_EN = 3'h3,
    REG_PULL_UP = 3'h2,
    REG_IN      = 3'h6,
    REG_FUNC    = 3'h7,
    REG_STATUS  = 3'h5,
    REG_NONE    = 3'h4
  } reg_sel_t;

  typedef enum logic [1:0] {
    STRAP_WAIT = 2'b00,
    STRAP_HELD = 2'b01
  } strap_state_t;

endpackage

/* File: verilog/pin_pad_cell.sv */
`timescale 1ns/1ps
module pin_pad_cell
  import pin_mux_pkg::*;
(
  input  wire logic implemented,
  input  wire logic gpio_out,
  input  wire logic gpio_dir_out,
  input  wire logic pull_en,
  input  wire logic pull_up_sel,
  input  wire logic alt_sel,
  input  wire logic alt_out,
  input  wire logic alt_oe,
  output logic      pad_out,
  output logic      pad_oe,
  output logic      pad_pu_en,
  output logic      pad_pd_en
);

  always_comb
  begin
    if (alt_sel)
    begin
      pad_out = alt_out;
      pad_oe  = alt_oe & implemented;
    end
    else
    begin
      pad_out = gpio_out;
      pad_oe  = gpio_dir_out & implemented;
    end
    pad_pu_en = implemented & pull_en & pull_up_sel;
    pad_pd_en = implemented & pull_en & ~pull_up_sel;
  end

endmodule

/* File: verilog/strap_capture.sv */
`timescale 1ns/1ps
module strap_capture
  import pin_mux_pkg::*;
(
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic strap_pin,
  output logic      spi_mode,
  output logic      captured
);

  typedef struct packed {
    strap_state_t st;
    logic         level;
  } strap_regs_t;

  strap_regs_t s_q;
  strap_regs_t s_d;

  // Level is caught on the first edge after release, never by the reset itself
  always_comb
  begin
    s_d = s_q;
    case (s_q.st)
      STRAP_WAIT:
      begin
        s_d.level = strap_pin;
        s_d.st    = STRAP_HELD;
      end
      STRAP_HELD:
      begin
        s_d = s_q;
      end
      default:
      begin
        s_d.st = STRAP_WAIT;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      s_q <= '{st: STRAP_WAIT, level: 1'b0};
    else
      s_q <= s_d;
  end

  assign spi_mode = s_q.level;
  assign captured = (s_q.st == STRAP_HELD);

endmodule

/* File: verilog/gpio_coex_uart_pin_mux.sv */
// Contract
// - Five general-purpose pins connect external devices under software control.
// - After reset every general-purpose pin is high impedance until configured; pins 3 to 5 instead follow coexistence_pin_function_oe.
// - Software sets each pin as input or output via a control register.
// - Software enables an internal pull-up or pull-down on each pin.
// - Pin 0 level is sampled as strap choosing SD-style or SPI host mode.
// - Pins 3, 4 and 5 perform the coexistence function after reset.
// - Software can switch pins 3, 4 and 5 to ordinary general-purpose behaviour.
// - Pin 1 is plain general-purpose after reset; software may route frequency signal.
// - Debug serial port on test-access pins is off unless software selects it.
// - Selected debug serial takes receive from data-in, drives transmit on data-out.
`timescale 1ns/1ps
module gpio_coex_uart_pin_mux
  import pin_mux_pkg::*;
(
  input  wire logic                pclk,
  input  wire logic                presetn,
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [ADDR_W-1:0]   paddr,
  input  wire logic [DATA_W-1:0]   pwdata,
  input  wire logic [3:0]          pstrb,
  output logic      [DATA_W-1:0]   prdata,
  output logic                     pready,
  output logic                     pslverr,
  input  wire logic [PIN_W-1:0]    gpio_pin_in,
  output logic      [PIN_W-1:0]    gpio_pin_out,
  output logic      [PIN_W-1:0]    gpio_pin_oe,
  output logic      [PIN_W-1:0]    gpio_pull_up_en,
  output logic      [PIN_W-1:0]    gpio_pull_dn_en,
  input  wire logic [COEX_W-1:0]   coexistence_pin_function_out,
  input  wire logic [COEX_W-1:0]   coexistence_pin_function_oe,
  output logic      [COEX_W-1:0]   coexistence_pin_function_in,
  input  wire logic                coex_frequency_signal,
  output logic                     host_spi_mode,
  output logic                     host_mode_valid,
  input  wire logic                test_data_in_pin,
  output logic                     test_data_out_pin,
  output logic                     test_data_out_oe,
  output logic                     scan_tdi,
  input  wire logic                scan_tdo,
  input  wire logic                scan_tdo_oe,
  input  wire logic                debug_uart_tx,
  output logic                     debug_uart_rx
);

  typedef struct packed {
    logic [PIN_W-1:0]  out;
    logic [PIN_W-1:0]  dir;
    logic [PIN_W-1:0]  pull_en;
    logic [PIN_W-1:0]  pull_up;
    logic [PIN_W-1:0]  pin_in;
    logic [FUNC_W-1:0] func;
    logic [DATA_W-1:0] rdata;
    logic              err;
  } regs_t;

  regs_t r_q;
  regs_t r_d;

  logic [PIN_W-1:0] alt_sel;
  logic [PIN_W-1:0] alt_out;
  logic [PIN_W-1:0] alt_oe;
  logic             strap_spi;
  logic             strap_done;
  logic             setup_phase;
  logic             access_phase;
  reg_sel_t         rd_sel;
  reg_sel_t         wr_sel;
  logic [DATA_W-1:0] rd_word;

  // Shared address decode for the read and write paths
  function automatic reg_sel_t decode_reg(input logic [ADDR_W-1:0] a);
    reg_sel_t s;
    case (a)
      ADDR_OUT:     s = REG_OUT;
      ADDR_DIR:     s = REG_DIR;
      ADDR_PULL_EN: s = REG_PULL_EN;
      ADDR_PULL_UP: s = REG_PULL_UP;
      ADDR_IN:      s = REG_IN;
      ADDR_FUNC:    s = REG_FUNC;
      ADDR_STATUS:  s = REG_STATUS;
      default:      s = REG_NONE;
    endcase
    return s;
  endfunction

  // Only lane 0 carries live bits; other lanes are ignored
  function automatic logic [PIN_W-1:0] merge_pins(
    input logic [PIN_W-1:0]  old,
    input logic [DATA_W-1:0] wd,
    input logic              lane0
  );
    logic [PIN_W-1:0] v;
    v = lane0 ? (wd[PIN_W-1:0] & PIN_IMPL_MASK) : old;
    return v;
  endfunction

  assign setup_phase  = psel & ~penable;
  assign access_phase = psel & penable;
  assign rd_sel       = decode_reg(paddr);
  assign wr_sel       = decode_reg(paddr);

  // Read word is formed in setup and held in a flop for the access phase
  always_comb
  begin
    rd_word = RST_DATA;
    case (rd_sel)
      REG_OUT:
      begin
        rd_word[PIN_W-1:0] = r_q.out;
      end
      REG_DIR:
      begin
        rd_word[PIN_W-1:0] = r_q.dir;
      end
      REG_PULL_EN:
      begin
        rd_word[PIN_W-1:0] = r_q.pull_en;
      end
      REG_PULL_UP:
      begin
        rd_word[PIN_W-1:0] = r_q.pull_up;
      end
      REG_IN:
      begin
        rd_word[PIN_W-1:0] = r_q.pin_in;
      end
      REG_FUNC:
      begin
        rd_word[FUNC_W-1:0] = r_q.func;
      end
      REG_STATUS:
      begin
        rd_word[STAT_SPI_MODE] = strap_spi;
        rd_word[STAT_STRAP_OK] = strap_done;
      end
      default:
      begin
        rd_word = RST_DATA;
      end
    endcase
  end

  always_comb
  begin
    r_d = r_q;
    r_d.pin_in = gpio_pin_in & PIN_IMPL_MASK;
    if (setup_phase)
    begin
      r_d.rdata = pwrite ? RST_DATA : rd_word;
      r_d.err   = (rd_sel == REG_NONE);
    end
    if (access_phase && pwrite)
    begin
      case (wr_sel)
        REG_OUT:
        begin
          r_d.out = merge_pins(r_q.out, pwdata, pstrb[0]);
        end
        REG_DIR:
        begin
          r_d.dir = merge_pins(r_q.dir, pwdata, pstrb[0]);
        end
        REG_PULL_EN:
        begin
          r_d.pull_en = merge_pins(r_q.pull_en, pwdata, pstrb[0]);
        end
        REG_PULL_UP:
        begin
          r_d.pull_up = merge_pins(r_q.pull_up, pwdata, pstrb[0]);
        end
        REG_FUNC:
        begin
          if (pstrb[0])
          begin
            r_d.func = pwdata[FUNC_W-1:0];
          end
        end
        default:
        begin
          r_d.func = r_q.func;
        end
      endcase
    end
  end

  // GPIO drivers and pulls off at reset; coexistence enables still drive pins 3 to 5
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      r_q.out     <= RST_PINS;
      r_q.dir     <= RST_PINS;
      r_q.pull_en <= RST_PINS;
      r_q.pull_up <= RST_PINS;
      r_q.pin_in  <= RST_PINS;
      r_q.func    <= RST_FUNC;
      r_q.rdata   <= RST_DATA;
      r_q.err     <= 1'b0;
    end
    else
    begin
      r_q <= r_d;
    end
  end

  // Zero-wait slave: answer lands in the first access cycle
  assign pready  = access_phase;
  assign prdata  = r_q.rdata;
  assign pslverr = access_phase & r_q.err;

  strap_capture u_strap (
    .pclk      (pclk),
    .presetn   (presetn),
    .strap_pin (gpio_pin_in[PIN_STRAP]),
    .spi_mode  (strap_spi),
    .captured  (strap_done)
  );

  assign host_spi_mode   = strap_spi;
  assign host_mode_valid = strap_done;

  // Alternate function routing per pin
  always_comb
  begin
    alt_sel = RST_PINS;
    alt_out = RST_PINS;
    alt_oe  = RST_PINS;
    // coexistence default on pins 3 to 5
    alt_sel[PIN_COEX_LO +: COEX_W] = {COEX_W{~r_q.func[FUNC_COEX_GPIO]}};
    alt_out[PIN_COEX_LO +: COEX_W] = coexistence_pin_function_out;
    alt_oe[PIN_COEX_LO +: COEX_W]  = coexistence_pin_function_oe;
    alt_sel[PIN_FREQ] = r_q.func[FUNC_FREQ_OUT];
    alt_out[PIN_FREQ] = coex_frequency_signal;
    alt_oe[PIN_FREQ]  = 1'b1;
  end

  // Coexistence logic sees idle low inputs once the pins are given to software
  assign coexistence_pin_function_in =
    gpio_pin_in[PIN_COEX_LO +: COEX_W] & alt_sel[PIN_COEX_LO +: COEX_W];

  genvar gi;
  generate
    for (gi = 0; gi < PIN_W; gi++)
    begin : g_pad
      pin_pad_cell u_pad (
        .implemented  (PIN_IMPL_MASK[gi]),
        .gpio_out     (r_q.out[gi]),
        .gpio_dir_out (r_q.dir[gi]),
        .pull_en      (r_q.pull_en[gi]),
        .pull_up_sel  (r_q.pull_up[gi]),
        .alt_sel      (alt_sel[gi]),
        .alt_out      (alt_out[gi]),
        .alt_oe       (alt_oe[gi]),
        .pad_out      (gpio_pin_out[gi]),
        .pad_oe       (gpio_pin_oe[gi]),
        .pad_pu_en    (gpio_pull_up_en[gi]),
        .pad_pd_en    (gpio_pull_dn_en[gi])
      );
    end
  endgenerate

  // Test-access pins: scan logic keeps them unless the debug port is chosen
  always_comb
  begin
    if (r_q.func[FUNC_UART_EN])
    begin
      debug_uart_rx     = test_data_in_pin;
      test_data_out_pin = debug_uart_tx;
      test_data_out_oe  = 1'b1;
      scan_tdi          = 1'b1;
    end
    else
    begin
      // Serial line idles high so the receiver sees no false start bit
      debug_uart_rx     = 1'b1;
      test_data_out_pin = scan_tdo;
      test_data_out_oe  = scan_tdo_oe;
      scan_tdi          = test_data_in_pin;
    end
  end

endmodule

/* File: dv/pin_world.sv */
`timescale 1ns/1ps
module pin_world
  import pin_mux_pkg::*;
(
  input  wire logic             pclk,
  input  wire logic [PIN_W-1:0] pad_out,
  input  wire logic [PIN_W-1:0] pad_oe,
  input  wire logic [PIN_W-1:0] pu,
  input  wire logic [PIN_W-1:0] pd,
  input  wire logic [PIN_W-1:0] ext,
  input  wire logic [PIN_W-1:0] ext_oe,
  output logic      [PIN_W-1:0] level
);
  logic [PIN_W-1:0] last_q = '0;

  // board drives pins
  // Floating pin flips each cycle so no stale level passes
  always_comb
  begin
    for (int i = 0; i < PIN_W; i++)
    begin
      level[i] = pad_oe[i] ? pad_out[i] : ext_oe[i] ? ext[i] : pu[i] | (~pd[i] & ~last_q[i]);
    end
  end

  always_ff @(posedge pclk)
  begin
    last_q <= level;
  end
endmodule

/* File: dv/pin_mux_sva.sv */
`timescale 1ns/1ps
module pin_mux_sva
  import pin_mux_pkg::*;
(
  input wire logic              pclk,
  input wire logic              presetn,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic              pready,
  input wire logic [PIN_W-1:0]  gpio_pin_in,
  input wire logic [PIN_W-1:0]  gpio_pin_oe,
  input wire logic [PIN_W-1:0]  gpio_pull_up_en,
  input wire logic [PIN_W-1:0]  gpio_pull_dn_en,
  input wire logic [COEX_W-1:0] coexistence_pin_function_oe,
  input wire logic [COEX_W-1:0] coexistence_pin_function_in,
  input wire logic              host_spi_mode,
  input wire logic              host_mode_valid,
  input wire logic              test_data_in_pin,
  input wire logic              test_data_out_pin,
  input wire logic              test_data_out_oe,
  input wire logic              debug_uart_tx,
  input wire logic              debug_uart_rx
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_pin2_idle: assert property (!gpio_pin_oe[2])
    else $error("unbonded pin driven");
  a_reset_float: assert property ($rose(host_mode_valid) |-> gpio_pin_oe[1:0] == 2'b00)
    else $error("pin driven after reset");
  a_dir_hold: assert property (!(psel && penable && pwrite) |=> $stable(gpio_pin_oe[1:0]))
    else $error("direction moved without write");
  a_pull_hold: assert property (!(psel && penable && pwrite) |=> $stable(gpio_pull_up_en))
    else $error("pull moved without write");
  a_strap_take: assert property ($rose(host_mode_valid) |-> host_spi_mode == $past(gpio_pin_in[0]))
    else $error("strap level not taken");
  a_strap_hold: assert property (host_mode_valid |=> host_mode_valid && $stable(host_spi_mode))
    else $error("strap result moved");
  a_coex_follow: assert property (|coexistence_pin_function_in |-> gpio_pin_oe[5:3] == coexistence_pin_function_oe)
    else $error("coex enable not followed");
  a_uart_route: assert property (!debug_uart_rx |-> !test_data_in_pin && test_data_out_oe && test_data_out_pin == debug_uart_tx)
    else $error("serial route wrong");
  a_zero_wait: assert property (psel && !penable |=> !penable || pready)
    else $error("access not answered");
endmodule

bind gpio_coex_uart_pin_mux pin_mux_sva chk (.*);

/* File: dv/gpio_coex_uart_pin_mux_bench.sv */
`timescale 1ns/1ps
module gpio_coex_uart_pin_mux_bench
  import pin_mux_pkg::*;
;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
  logic [ADDR_W-1:0] paddr;
  logic [DATA_W-1:0] pwdata, prdata, rd;
  logic [3:0] pstrb;
  logic [PIN_W-1:0] gpio_pin_in, gpio_pin_out, gpio_pin_oe, gpio_pull_up_en, gpio_pull_dn_en;
  logic [PIN_W-1:0] ext, ext_oe;
  logic [COEX_W-1:0] coexistence_pin_function_out, coexistence_pin_function_oe;
  logic [COEX_W-1:0] coexistence_pin_function_in;
  logic coex_frequency_signal, host_spi_mode, host_mode_valid, test_data_in_pin;
  logic test_data_out_pin, test_data_out_oe, scan_tdi, scan_tdo, scan_tdo_oe;
  logic debug_uart_tx, debug_uart_rx;
  int fail_count, n_compared, cyc;
  logic [ADDR_W-1:0] ra [6] = '{ADDR_OUT, ADDR_DIR, ADDR_PULL_EN, ADDR_PULL_UP, ADDR_FUNC, ADDR_STATUS};

  gpio_coex_uart_pin_mux dut (.*);

  pin_world world (
    .pclk    (pclk),
    .pad_out (gpio_pin_out),
    .pad_oe  (gpio_pin_oe),
    .pu      (gpio_pull_up_en),
    .pd      (gpio_pull_dn_en),
    .ext     (ext),
    .ext_oe  (ext_oe),
    .level   (gpio_pin_in)
  );

  always #4 pclk = ~pclk;

  task automatic print_verdict;
    if (fail_count == 0 && n_compared > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("mismatch %0t seen %h want %h", $time, seen, exp);
    end
  endtask

  // Idle cycle between transfers keeps each signal to one write per step
  task automatic xfer(input logic w, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(negedge pclk);
  endtask

  always @(posedge pclk)
  begin
    cyc++;
    if (cyc == 2000)
    begin
      fail_count++;
      $display("mismatch %0t timeout", $time);
      print_verdict;
    end
  end

  initial
  begin
    {pclk, presetn, psel, penable, pwrite, paddr, pwdata, scan_tdo_oe, debug_uart_tx} = '0;
    {coex_frequency_signal, scan_tdo, test_data_in_pin} = 3'b111;
    pstrb = 4'hF;
    ext = 6'h31;
    ext_oe = 6'h39;
    coexistence_pin_function_out = 3'b001;
    coexistence_pin_function_oe = 3'b101;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    repeat (3) @(negedge pclk);
    chk(gpio_pin_oe[2:0], 3'b000);
    chk(gpio_pin_oe[5:3], 3'b101);
    chk(coexistence_pin_function_in, 3'b011);
    chk({debug_uart_rx, test_data_out_oe, test_data_out_pin, scan_tdi}, 4'b1011);
    chk({gpio_pull_up_en, gpio_pull_dn_en}, 12'h000);
    chk({host_spi_mode, host_mode_valid}, 2'b11);
    for (int i = 0; i < 6; i++)
    begin
      xfer(1'b0, ra[i], '0);
      chk(rd, (i == 5) ? 32'h0000_0003 : 32'h0000_0000);
    end
    xfer(1'b1, ADDR_DIR, 32'h0000_0003);
    xfer(1'b1, ADDR_OUT, 32'h0000_0002);
    chk({gpio_pin_oe[1:0], gpio_pin_out[1:0]}, 4'b1110);
    xfer(1'b1, ADDR_PULL_EN, 32'h0000_0030);
    xfer(1'b1, ADDR_PULL_UP, 32'h0000_0010);
    chk({gpio_pull_up_en, gpio_pull_dn_en}, 12'h420);
    @(posedge pclk);
    ext_oe <= 6'h01;
    xfer(1'b1, ADDR_FUNC, 32'h0000_0001);
    chk({gpio_pin_oe[5:3], coexistence_pin_function_in}, 6'h00);
    xfer(1'b0, ADDR_IN, '0);
    chk(rd & 32'h0000_0037, 32'h0000_0012);
    xfer(1'b0, ADDR_STATUS, '0);
    chk(rd, 32'h0000_0003);
    xfer(1'b1, ADDR_DIR, 32'h0000_0039);
    xfer(1'b1, ADDR_OUT, 32'h0000_0028);
    chk({gpio_pin_oe[5:3], gpio_pin_out[5:3]}, 6'h3D);
    xfer(1'b1, ADDR_FUNC, 32'h0000_0003);
    chk({gpio_pin_oe[1], gpio_pin_out[1]}, 2'b11);
    xfer(1'b1, ADDR_FUNC, 32'h0000_0004);
    chk({gpio_pin_oe[5:3], gpio_pin_oe[1]}, 4'hA);
    chk({test_data_out_oe, test_data_out_pin}, 2'b10);
    @(posedge pclk);
    debug_uart_tx <= 1'b1;
    test_data_in_pin <= 1'b0;
    @(negedge pclk);
    chk({debug_uart_rx, test_data_out_pin, scan_tdi}, 3'b011);
    // Writes without the low byte strobe must leave the register alone
    @(posedge pclk);
    pstrb <= 4'h0;
    xfer(1'b1, ADDR_DIR, 32'h0000_0000);
    @(posedge pclk);
    pstrb <= 4'hF;
    xfer(1'b0, ADDR_DIR, '0);
    chk(rd, 32'h0000_0039);
    xfer(1'b0, 12'h100, '0);
    chk(er, 1'b1);
    chk(rd, 32'h0000_0000);
    // Second reset with the strap pulled low selects the SD-style host mode
    @(posedge pclk);
    presetn <= 1'b0;
    ext <= 6'h30;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    repeat (3) @(negedge pclk);
    chk({host_spi_mode, host_mode_valid, gpio_pin_oe}, 8'h68);
    chk({debug_uart_rx, test_data_out_oe}, 2'b10);
    print_verdict;
  end
endmodule
